// *** src/cbr_defines.svh ***
// timing, encoding and sizing constants for the cross-bank command checker
`ifndef CBR_DEFINES_SVH
`define CBR_DEFINES_SVH

`define CBR_CLK_PS       20000
`define CBR_TRCD_PS      15000
`define CBR_TRP_PS       15000
`define CBR_TWR_PS       15000
`define CBR_TWTR_PS      7500
`define CBR_CEIL_CYC(ps) (((ps) + `CBR_CLK_PS - 1) / `CBR_CLK_PS)
`define CBR_TRCD_CYC     `CBR_CEIL_CYC(`CBR_TRCD_PS)
`define CBR_TRP_CYC      `CBR_CEIL_CYC(`CBR_TRP_PS)
`define CBR_TWR_CYC      `CBR_CEIL_CYC(`CBR_TWR_PS)
`define CBR_TWTR_MIN     2
`define CBR_TWTR_CYC     ((`CBR_CEIL_CYC(`CBR_TWTR_PS) > `CBR_TWTR_MIN) ? \
                          `CBR_CEIL_CYC(`CBR_TWTR_PS) : `CBR_TWTR_MIN)
`define CBR_XSNR_CYC     200
`define CBR_BANKS        8
`define CBR_AP_GAP       1
`define CBR_RD_WR_EXTRA  2
`define CBR_BL4_HALF     6'h02
`define CBR_BL8_HALF     6'h04
`define CBR_SINCE_MAX    8'hff

`endif

// *** src/cbr_pkg.sv ***
// command, bank state and command carrier types
package cbr_pkg;

	typedef enum logic [2:0] {
		CBR_OP_NONE = 3'b000,
		CBR_OP_ACT  = 3'b001,
		CBR_OP_RD   = 3'b010,
		CBR_OP_WR   = 3'b011,
		CBR_OP_PRE  = 3'b100,
		CBR_OP_REF  = 3'b101,
		CBR_OP_LMR  = 3'b110
	} cbr_op_t;

	typedef enum logic [2:0] {
		CBR_ST_IDLE    = 3'b000,
		CBR_ST_OPENING = 3'b001,
		CBR_ST_ACTIVE  = 3'b010,
		CBR_ST_READ    = 3'b011,
		CBR_ST_WRITE   = 3'b100,
		CBR_ST_RD_AP   = 3'b101,
		CBR_ST_WR_AP   = 3'b110,
		CBR_ST_PRECH   = 3'b111
	} cbr_bank_st_t;

	typedef struct packed {
		logic        vld;
		cbr_op_t     op;
		logic [2:0]  bank;
		logic        ap;
	} cbr_cmd_t;

endpackage

// *** src/cbr_bank.sv ***
// per-bank state tracker with auto precharge access and precharge periods
`timescale 1ns/10ps
`include "cbr_defines.svh"
module cbr_bank #(
	parameter int IDX = 0
) (
	// clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	// command accepted on this edge, and mode
	input  wire cbr_pkg::cbr_cmd_t     i_cmd,
	input  wire logic [2:0]            i_cas_lat,
	input  wire logic                  i_burst8,
	// bank status
	output cbr_pkg::cbr_bank_st_t      o_state,
	output logic                       o_rd_busy
);
	import cbr_pkg::*;

	localparam logic [5:0] TRCD = 6'(`CBR_TRCD_CYC);
	localparam logic [5:0] TRP  = 6'(`CBR_TRP_CYC);
	localparam logic [5:0] TWR  = 6'(`CBR_TWR_CYC);

	cbr_bank_st_t st_r, st_nxt;
	logic [5:0]   cnt_r, cnt_nxt;
	logic [5:0]   dat_r, dat_nxt;
	logic [5:0]   dwell_r, dwell_nxt;
	logic [5:0]   bl2, clm1;
	logic         hit;

	assign bl2  = i_burst8 ? `CBR_BL8_HALF : `CBR_BL4_HALF;
	assign clm1 = {3'h0, i_cas_lat} - 6'h01;
	assign hit  = i_cmd.vld && (i_cmd.bank == 3'(IDX) || (i_cmd.op == CBR_OP_PRE && i_cmd.ap));

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = (cnt_r == 6'h00) ? 6'h00 : cnt_r - 6'h01;
		dat_nxt = (dat_r == 6'h00) ? 6'h00 : dat_r - 6'h01;
		if (hit && i_cmd.op == CBR_OP_ACT) begin
			st_nxt  = CBR_ST_OPENING;
			cnt_nxt = TRCD - 6'h01;
		end else if (hit && i_cmd.op == CBR_OP_RD) begin
			st_nxt  = i_cmd.ap ? CBR_ST_RD_AP : CBR_ST_READ;
			cnt_nxt = bl2 - 6'h01;
			dat_nxt = {3'h0, i_cas_lat} + bl2;
		end else if (hit && i_cmd.op == CBR_OP_WR) begin
			st_nxt  = i_cmd.ap ? CBR_ST_WR_AP : CBR_ST_WRITE;
			cnt_nxt = i_cmd.ap ? clm1 + bl2 + TWR - 6'h01 : clm1 + bl2 - 6'h01;
		end else if (hit && i_cmd.op == CBR_OP_PRE) begin
			st_nxt  = (st_r == CBR_ST_IDLE) ? CBR_ST_IDLE : CBR_ST_PRECH;
			cnt_nxt = TRP - 6'h01;
		end else if (cnt_r == 6'h00) begin
			case (st_r)
				CBR_ST_OPENING, CBR_ST_READ, CBR_ST_WRITE: begin
					st_nxt = CBR_ST_ACTIVE;
				end
				CBR_ST_RD_AP, CBR_ST_WR_AP: begin
					st_nxt  = CBR_ST_PRECH;
					cnt_nxt = TRP - 6'h01;
				end
				CBR_ST_PRECH: begin
					if (dat_r == 6'h00) begin
						st_nxt = CBR_ST_IDLE;
					end
				end
				default: begin
					st_nxt = st_r;
				end
			endcase
		end
		dwell_nxt = (st_nxt != st_r) ? 6'h01 :
			(dwell_r == 6'h3f) ? dwell_r : dwell_r + 6'h01;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_r    <= CBR_ST_IDLE;
			cnt_r   <= 6'h00;
			dat_r   <= 6'h00;
			dwell_r <= 6'h01;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			dat_r   <= dat_nxt;
			dwell_r <= dwell_nxt;
		end
	end

	assign o_state   = st_r;
	assign o_rd_busy = (dat_r != 6'h00);

	chk_idle_no_burst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_r == CBR_ST_IDLE |-> dat_r == 6'h00)
		else $error("bank went idle with a read burst still running");
	chk_rdap_prech_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(hit && i_cmd.op == CBR_OP_RD && i_cmd.ap && i_burst8)
		|=> (st_r == CBR_ST_RD_AP)[*4] ##1 st_r == CBR_ST_PRECH)
		else $error("read auto precharge did not start precharge after half burst");
	chk_wrap_recovery: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == CBR_ST_WR_AP && st_nxt == CBR_ST_PRECH)
		|-> dwell_r == clm1 + bl2 + TWR)
		else $error("write auto precharge precharge not after write recovery");
	chk_prech_period: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_r == CBR_ST_PRECH && st_nxt == CBR_ST_IDLE) |-> dwell_r >= TRP)
		else $error("precharge period shorter than row precharge time");
endmodule

// *** src/cbr_top.sv ***
// device-side command decoder and cross-bank legality checker
// Behaviour
// - commands decoded from pins at rising edge
// - decode only with CKE high twice, after exit delay
// - CS# high ignores commands, operations continue
// - NOP registers nothing, operations continue
// - pin patterns decode ACTIVATE, READ, WRITE, PRECHARGE
// - idle after precharge, tRP and read burst end
// - read auto precharge starts at earliest precharge
// - write auto precharge starts after tWR
// - access period then precharge period until tRP
// - other banks accept commands during auto precharge
`timescale 1ns/10ps
`include "cbr_defines.svh"
module cbr_top #(
	parameter int BANKS    = `CBR_BANKS,
	parameter int XSNR_CYC = `CBR_XSNR_CYC
) (
	// clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_n,
	// command pins
	input  wire logic                i_cke,
	input  wire logic                i_cs_n,
	input  wire logic                i_ras_n,
	input  wire logic                i_cas_n,
	input  wire logic                i_we_n,
	input  wire logic [2:0]          i_ba,
	input  wire logic                i_a10,
	// mode settings
	input  wire logic [2:0]          i_cas_lat,
	input  wire logic                i_burst8,
	// decoded results
	output cbr_pkg::cbr_cmd_t        o_cmd,
	output logic                     o_ignored,
	output logic                     o_illegal,
	output logic [BANKS-1:0]         o_bank_idle
);
	import cbr_pkg::*;

	localparam logic [7:0] TWTR = 8'(`CBR_TWTR_CYC);
	localparam logic [7:0] GAP  = 8'(`CBR_AP_GAP);
	localparam logic [7:0] XTRA = 8'(`CBR_RD_WR_EXTRA);
	localparam logic [7:0] XSNR = 8'(XSNR_CYC);

	cbr_bank_st_t     bst [BANKS];
	logic [BANKS-1:0] rd_busy;

	logic       cke_prev_r, cke_prev_nxt;
	logic [7:0] xs_cnt_r, xs_cnt_nxt;
	cbr_cmd_t   cmd_r, cmd_nxt;
	logic       ign_r, ign_nxt;
	logic       ill_r, ill_nxt;
	logic [7:0] wr_since_r, wr_since_nxt, rd_since_r, rd_since_nxt;
	logic [2:0] wr_bank_r, wr_bank_nxt, rd_bank_r, rd_bank_nxt;
	logic       wr_ap_r, wr_ap_nxt, rd_ap_r, rd_ap_nxt;

	cbr_cmd_t     dec;
	cbr_bank_st_t tgt;
	logic         live, all_idle, pre_all_ok, bad_state, bad_cross, other_rd;
	logic [7:0]   bl2, clm1;

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : gen_bank
			cbr_bank #(.IDX(g)) u_bank (
				.i_core_clk (i_core_clk),
				.i_rst_n    (i_rst_n),
				.i_cmd      (cmd_nxt),
				.i_cas_lat  (i_cas_lat),
				.i_burst8   (i_burst8),
				.o_state    (bst[g]),
				.o_rd_busy  (rd_busy[g])
			);
			assign o_bank_idle[g] = (bst[g] == CBR_ST_IDLE);
		end
	endgenerate

	assign bl2  = {2'h0, (i_burst8 ? `CBR_BL8_HALF : `CBR_BL4_HALF)};
	assign clm1 = {5'h00, i_cas_lat} - 8'h01;
	assign live = cke_prev_r && i_cke && xs_cnt_r == 8'h00;

	// pin decode, sampled at the rising edge
	always_comb begin
		dec      = '0;
		dec.bank = i_ba;
		dec.ap   = i_a10;
		if (live && !i_cs_n) begin
			dec.vld = 1'b1;
			case ({i_ras_n, i_cas_n, i_we_n})
				3'b011: dec.op = CBR_OP_ACT;
				3'b101: dec.op = CBR_OP_RD;
				3'b100: dec.op = CBR_OP_WR;
				3'b010: dec.op = CBR_OP_PRE;
				3'b001: dec.op = CBR_OP_REF;
				3'b000: dec.op = CBR_OP_LMR;
				default: begin
					dec.vld = 1'b0;
					dec.op  = CBR_OP_NONE;
				end
			endcase
		end
	end

	// legality against target bank state and other banks
	always_comb begin
		all_idle   = 1'b1;
		pre_all_ok = 1'b1;
		other_rd   = 1'b0;
		for (int b = 0; b < BANKS; b++) begin
			all_idle   = all_idle && bst[b] == CBR_ST_IDLE;
			pre_all_ok = pre_all_ok && (bst[b] == CBR_ST_IDLE || bst[b] == CBR_ST_ACTIVE ||
				bst[b] == CBR_ST_READ || bst[b] == CBR_ST_WRITE);
			other_rd   = other_rd || (rd_busy[b] && 3'(b) != dec.bank);
		end
		tgt       = bst[dec.bank];
		bad_state = 1'b0;
		case (dec.op)
			CBR_OP_ACT: bad_state = (tgt != CBR_ST_IDLE);
			CBR_OP_RD, CBR_OP_WR: bad_state = !(tgt == CBR_ST_ACTIVE ||
				tgt == CBR_ST_READ || tgt == CBR_ST_WRITE);
			CBR_OP_PRE: bad_state = dec.ap ? !pre_all_ok : !(tgt == CBR_ST_IDLE ||
				tgt == CBR_ST_ACTIVE || tgt == CBR_ST_READ || tgt == CBR_ST_WRITE);
			CBR_OP_REF, CBR_OP_LMR: bad_state = !all_idle;
			default: bad_state = 1'b0;
		endcase
		bad_cross = 1'b0;
		case (dec.op)
			CBR_OP_RD: begin
				bad_cross = (wr_bank_r != dec.bank && wr_since_r < clm1 + bl2 + TWTR) ||
					(rd_ap_r && rd_bank_r != dec.bank && rd_since_r < bl2);
			end
			CBR_OP_WR: begin
				bad_cross = other_rd ||
					(rd_ap_r && rd_bank_r != dec.bank && rd_since_r < bl2 + XTRA) ||
					(wr_ap_r && wr_bank_r != dec.bank && wr_since_r < bl2);
			end
			CBR_OP_ACT, CBR_OP_PRE: begin
				bad_cross = (rd_ap_r && rd_bank_r != dec.bank && rd_since_r < GAP) ||
					(wr_ap_r && wr_bank_r != dec.bank && wr_since_r < GAP);
			end
			default: bad_cross = 1'b0;
		endcase
	end

	// next values: accepted command, history of column commands
	always_comb begin
		cke_prev_nxt = i_cke;
		xs_cnt_nxt   = (!cke_prev_r && i_cke) ? XSNR :
			(xs_cnt_r == 8'h00) ? 8'h00 : xs_cnt_r - 8'h01;
		ill_nxt      = dec.vld && (bad_state || bad_cross);
		ign_nxt      = !dec.vld;
		cmd_nxt      = dec;
		cmd_nxt.vld  = dec.vld && !ill_nxt;
		wr_since_nxt = (wr_since_r == `CBR_SINCE_MAX) ? wr_since_r : wr_since_r + 8'h01;
		rd_since_nxt = (rd_since_r == `CBR_SINCE_MAX) ? rd_since_r : rd_since_r + 8'h01;
		wr_bank_nxt  = wr_bank_r;
		rd_bank_nxt  = rd_bank_r;
		wr_ap_nxt    = wr_ap_r;
		rd_ap_nxt    = rd_ap_r;
		if (cmd_nxt.vld && dec.op == CBR_OP_WR) begin
			wr_since_nxt = 8'h01;
			wr_bank_nxt  = dec.bank;
			wr_ap_nxt    = dec.ap;
		end
		if (cmd_nxt.vld && dec.op == CBR_OP_RD) begin
			rd_since_nxt = 8'h01;
			rd_bank_nxt  = dec.bank;
			rd_ap_nxt    = dec.ap;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cke_prev_r <= 1'b0;
			xs_cnt_r   <= 8'h00;
			cmd_r      <= '0;
			ign_r      <= 1'b0;
			ill_r      <= 1'b0;
			wr_since_r <= `CBR_SINCE_MAX;
			rd_since_r <= `CBR_SINCE_MAX;
			wr_bank_r  <= 3'h0;
			rd_bank_r  <= 3'h0;
			wr_ap_r    <= 1'b0;
			rd_ap_r    <= 1'b0;
		end else begin
			cke_prev_r <= cke_prev_nxt;
			xs_cnt_r   <= xs_cnt_nxt;
			cmd_r      <= cmd_nxt;
			ign_r      <= ign_nxt;
			ill_r      <= ill_nxt;
			wr_since_r <= wr_since_nxt;
			rd_since_r <= rd_since_nxt;
			wr_bank_r  <= wr_bank_nxt;
			rd_bank_r  <= rd_bank_nxt;
			wr_ap_r    <= wr_ap_nxt;
			rd_ap_r    <= rd_ap_nxt;
		end
	end

	assign o_cmd     = cmd_r;
	assign o_ignored = ign_r;
	assign o_illegal = ill_r;

	chk_cke_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(!i_cke ##1 i_cke) |=> !o_cmd.vld && o_ignored)
		else $error("command accepted right after clock enable rose");
	chk_deselect_ign: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_cs_n |=> !o_cmd.vld && o_ignored && !o_illegal)
		else $error("deselected cycle produced a command");
	chk_nop_ign: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(!i_cs_n && i_ras_n && i_cas_n && i_we_n) |=> o_ignored && !o_cmd.vld)
		else $error("no-operation produced a command");
	chk_act_decode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(live && !i_cs_n && !i_ras_n && i_cas_n && i_we_n && bst[i_ba] == CBR_ST_IDLE &&
		!bad_cross) |=> o_cmd.vld && o_cmd.op == CBR_OP_ACT && o_cmd.bank == $past(i_ba))
		else $error("activate not decoded");
	chk_ref_all_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(dec.vld && dec.op == CBR_OP_REF && !all_idle) |=> o_illegal && !o_cmd.vld)
		else $error("refresh accepted with a bank not idle");
	chk_wr_during_rd: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(dec.vld && dec.op == CBR_OP_WR && other_rd) |=> o_illegal)
		else $error("write accepted during another bank read burst");
	chk_concurrent_ap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(dec.vld && dec.op == CBR_OP_ACT && tgt == CBR_ST_IDLE && rd_ap_r &&
		rd_bank_r != dec.bank && rd_since_r >= GAP) |=> o_cmd.vld)
		else $error("activate to other bank refused during auto precharge");

	cov_rd_ap: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cmd.vld && o_cmd.op == CBR_OP_RD && o_cmd.ap);
	cov_wr_ap: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cmd.vld && o_cmd.op == CBR_OP_WR && o_cmd.ap);
	cov_illegal: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_illegal);
endmodule

// *** testbench/cbr_ctl_model.sv ***
// controller-side model that encodes commands onto the device pins
`timescale 1ns/10ps
module cbr_ctl_model (
	// command request from the bench
	input  wire cbr_pkg::cbr_cmd_t i_req,
	input  wire logic              i_desel,
	input  wire logic [6:0]        i_noise,
	// device pins
	output logic                   o_cs_n,
	output logic                   o_ras_n,
	output logic                   o_cas_n,
	output logic                   o_we_n,
	output logic [2:0]             o_ba,
	output logic                   o_a10
);
	import cbr_pkg::*;

	logic [2:0] pat;

	always_comb begin
		// unused lines carry the bench noise, held until the bench changes it
		{pat, o_ba, o_a10} = i_noise;
		o_cs_n = 1'b0;
		if (i_req.vld) begin
			o_ba = i_req.bank;
			o_a10 = i_req.ap;
			case (i_req.op)
				CBR_OP_ACT: pat = 3'b011;
				CBR_OP_RD:  pat = 3'b101;
				CBR_OP_WR:  pat = 3'b100;
				CBR_OP_PRE: pat = 3'b010;
				CBR_OP_REF: pat = 3'b001;
				CBR_OP_LMR: pat = 3'b000;
				default:    pat = 3'b111;
			endcase
		end else if (i_desel) begin
			o_cs_n = 1'b1;
		end else begin
			pat = 3'b111;
		end
		{o_ras_n, o_cas_n, o_we_n} = pat;
	end
endmodule

// *** testbench/cross_bank_command_rules_test.sv ***
// self-checking bench for the cross-bank command checker
`timescale 1ns/10ps
module cross_bank_command_rules_test;
	import cbr_pkg::*;

	logic       i_core_clk = 1'b0;
	logic       i_rst_n = 1'b0;
	logic       i_cke = 1'b1;
	cbr_cmd_t   req = '0;
	logic       desel = 1'b0;
	logic       burst8 = 1'b1;
	logic [6:0] noise = '0;
	logic       cs_n, ras_n, cas_n, we_n, a10;
	logic [2:0] ba;
	cbr_cmd_t   o_cmd;
	logic       o_ignored, o_illegal;
	logic [7:0] o_bank_idle;
	logic [7:0] idle_hold;
	int         err_total = 0;
	int         comparisons = 0;
	int         seed = 32'he6c0;

	localparam int ACC = 0;
	localparam int ILL = 1;
	localparam int IGN = 2;

	always #10 i_core_clk = ~i_core_clk;

	cbr_ctl_model ctl (.i_req(req), .i_desel(desel), .i_noise(noise), .o_cs_n(cs_n),
		.o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_a10(a10));

	cbr_top #(.BANKS(8), .XSNR_CYC(4)) uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_cke(i_cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
		.i_ba(ba), .i_a10(a10), .i_cas_lat(3'h3), .i_burst8(burst8), .o_cmd(o_cmd),
		.o_ignored(o_ignored), .o_illegal(o_illegal), .o_bank_idle(o_bank_idle));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic cbr_cmd_t exp_cmd(input cbr_op_t op, input logic [2:0] b, input logic ap);
		exp_cmd = '{vld: 1'b1, op: op, bank: b, ap: ap};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	// one command cycle, then the registered answer one edge later
	task automatic issue(input cbr_op_t op, input logic [2:0] b, input logic ap, input int res);
		cbr_cmd_t e;
		e = exp_cmd(op, b, ap);
		tick(1);
		req = e;
		noise = 7'($random(seed));
		tick(1);
		req = '0;
		check("accepted", o_cmd.vld, res == ACC);
		check("illegal", o_illegal, res == ILL);
		check("ignored", o_ignored, res == IGN);
		if (res == ACC)
			check("cmd", o_cmd[7:1], e[7:1]);
		if (res == ACC && (op == CBR_OP_RD || op == CBR_OP_WR))
			check("ap", o_cmd.ap, ap);
	endtask

	// random filler: deselect or nop with random unused lines
	task automatic filler(input logic sel_off);
		idle_hold = o_bank_idle;
		tick(1);
		desel = sel_off;
		noise = 7'($random(seed));
		tick(1);
		desel = 1'b0;
		check("filler ignored", o_ignored, 1'b1);
		check("filler cmd", o_cmd.vld, 1'b0);
		check("filler illegal", o_illegal, 1'b0);
		check("filler idle", o_bank_idle, idle_hold);
	endtask

	initial begin
		#(20 * 3000);
		err_total++;
		final_report();
	end

	initial begin
		tick(4);
		check("reset idle", o_bank_idle, 8'hff);
		check("reset cmd", o_cmd, 8'h00);
		i_rst_n = 1'b1;
		tick(8);
		for (int i = 0; i < 16; i++)
			filler(i[0]);
		issue(CBR_OP_ACT, 3'h0, 1'b0, ACC);
		check("bank0 busy", o_bank_idle[0], 1'b0);
		issue(CBR_OP_ACT, 3'h0, 1'b0, ILL);
		issue(CBR_OP_REF, 3'h0, 1'b0, ILL);
		issue(CBR_OP_LMR, 3'h0, 1'b0, ILL);
		issue(CBR_OP_ACT, 3'h1, 1'b0, ACC);
		issue(CBR_OP_RD, 3'h0, 1'b1, ACC);
		issue(CBR_OP_RD, 3'h1, 1'b0, ILL);
		issue(CBR_OP_WR, 3'h1, 1'b0, ILL);
		issue(CBR_OP_PRE, 3'h0, 1'b0, ILL);
		issue(CBR_OP_ACT, 3'h2, 1'b0, ACC);
		tick(14);
		check("bank0 back idle", o_bank_idle[0], 1'b1);
		issue(CBR_OP_WR, 3'h1, 1'b0, ACC);
		issue(CBR_OP_ACT, 3'h0, 1'b0, ACC);
		issue(CBR_OP_WR, 3'h1, 1'b1, ACC);
		issue(CBR_OP_WR, 3'h2, 1'b0, ILL);
		issue(CBR_OP_RD, 3'h0, 1'b0, ILL);
		issue(CBR_OP_PRE, 3'h2, 1'b0, ACC);
		tick(10);
		issue(CBR_OP_RD, 3'h0, 1'b0, ACC);
		tick(20);
		check("bank1 wr ap idle", o_bank_idle[1], 1'b1);
		issue(CBR_OP_PRE, 3'h0, 1'b1, ACC);
		tick(12);
		check("all idle", o_bank_idle, 8'hff);
		issue(CBR_OP_REF, 3'h0, 1'b0, ACC);
		i_cke = 1'b0;
		tick(3);
		i_cke = 1'b1;
		issue(CBR_OP_ACT, 3'h3, 1'b0, IGN);
		tick(8);
		issue(CBR_OP_ACT, 3'h3, 1'b0, ACC);
		check("bank3 busy", o_bank_idle, 8'hf7);
		// burst of four: read data and read-ap spacing both shrink
		burst8 = 1'b0;
		issue(CBR_OP_RD, 3'h3, 1'b1, ACC);
		issue(CBR_OP_ACT, 3'h4, 1'b0, ACC);
		issue(CBR_OP_WR, 3'h4, 1'b0, ILL);
		issue(CBR_OP_WR, 3'h4, 1'b0, ACC);
		check("bank3 bl4 idle", o_bank_idle[3], 1'b1);
		for (int i = 0; i < 16; i++)
			filler(i[1]);
		final_report();
	end
endmodule
